// *** pkg/aicr_pkg.sv ***
/*
 * Constants for the amplifier control register set: register order,
 * reset values, field positions, slave address layout and timing.
 * Assumes a single 250 MHz system clock.
 */
package aicr_pkg;

    // Register order on the wire, first byte first
    localparam logic [2:0] IDX_R_BTL = 3'h0;
    localparam logic [2:0] IDX_L_BTL = 3'h1;
    localparam logic [2:0] IDX_R_SE = 3'h2;
    localparam logic [2:0] IDX_L_SE = 3'h3;
    localparam logic [2:0] IDX_MASK = 3'h4;
    localparam logic [2:0] IDX_CTRL = 3'h5;
    localparam logic [2:0] NUM_REGS = 3'h6;

    localparam logic [7:0] GAIN_RST = 8'h3F;
    localparam logic [7:0] MASK_RST = 8'hFF;
    localparam logic [7:0] CTRL_RST = 8'h00;
    // Value returned for bytes read past the last register
    localparam logic [7:0] IDLE_BYTE = 8'hFF;

    // Gain register fields
    localparam int GAIN_CODE_W = 6;
    localparam int GAIN_MUTE_A = 6;
    localparam int GAIN_MUTE_B = 7;

    // Mask register fields
    localparam int MASK_PWRDN = 0;
    localparam int MASK_TOPO = 1;
    localparam int MASK_TONE = 2;
    localparam int MASK_BUSY = 7;

    // Control register fields
    localparam int CTRL_PWRDN = 0;
    localparam int CTRL_INSRC = 1;
    localparam int CTRL_MUTE = 3;
    localparam int CTRL_TOPO = 5;
    localparam int CTRL_GSEL = 6;
    localparam int CTRL_TONE = 7;

    // Slave address: fixed upper bits, then the two select pins
    localparam logic [4:0] ADDR_FIXED = 5'h1B;

    // Power-up sequence length
    localparam int CLK_PERIOD_NS = 4;
    localparam int PWRUP_TIME_NS = 10000;
    localparam int PWRUP_CYC = (PWRUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_AACK,
        ST_WR,
        ST_WACK,
        ST_RD,
        ST_RACK
    } aicr_state_t;

endpackage

// *** pkg/aicr_line_if.sv ***
/*
 * Carrier for the synchronised two-wire bus events between the line
 * synchroniser and the register set. Both ends run on the same clock.
 */
`timescale 1ns/1ns
interface aicr_line_if;
    logic scl_rise;
    logic scl_fall;
    logic sda;
    logic start;
    logic stop;

    modport src (output scl_rise, output scl_fall, output sda, output start, output stop);
    modport dst (input scl_rise, input scl_fall, input sda, input start, input stop);
endinterface

// *** design/aicr_line_sync.sv ***
/*
 * Two-flop synchroniser and event detector for the serial clock and
 * data lines. Assumes the bus runs far slower than clk.
 */
`timescale 1ns/1ns
module aicr_line_sync (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic scl_i,
    input wire logic sda_i,
    aicr_line_if.src ev
);
    logic [2:0] scl_q;
    logic [2:0] sda_q;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            scl_q <= 3'h7;
            sda_q <= 3'h7;
        end else begin
            scl_q <= {scl_q[1:0], scl_i};
            sda_q <= {sda_q[1:0], sda_i};
        end
    end

    // Only stages 1 and 2 are looked at; stage 0 feeds stage 1 alone
    assign ev.scl_rise = scl_q[1] & ~scl_q[2];
    assign ev.scl_fall = ~scl_q[1] & scl_q[2];
    assign ev.sda = sda_q[1];
    assign ev.start = scl_q[1] & scl_q[2] & ~sda_q[1] & sda_q[2];
    assign ev.stop = scl_q[1] & scl_q[2] & sda_q[1] & ~sda_q[2];
endmodule

// *** design/aicr_regs.sv ***
/*
 * Control register set of a stereo amplifier, reached over the two-wire
 * serial bus as one six-byte block, with pin/register override decode.
 * Assumes scl/sda and all pins are asynchronous to clk; sda is open drain.
 */
// Behaviour
// - A read returns six bytes, one per register, in one transfer.
// - Seven-bit slave address plus read/write bit; upper five bits fixed.
// - Address bits 1 and 0 come from the high and low select pins.
// - Gain code in bits 0-5, step 1.25 dB; gain registers reset to 0x3F.
// - Either bit 7 or bit 6 of the active gain register mutes.
// - Mask bits 0-2 pick pin (1) or control bit (0); mask resets 0xFF.
// - Mask bit 2 set keeps the tone input in automatic detection.
// - Mask bit 7 read-only, 1 during power-up, 0 afterwards.
// - Control bit 0 high requests power-down; control resets to 0x00.
// - Control bit 1 selects headphone inputs; mask bit 1 hands it to pin.
// - Control bit 3 mutes like the gain mute bits.
// - Control bit 5 picks single-ended output like the topology pin.
// - Control bit 6 picks the gain register pair, independent of topology.
// - With mask bit 1 set, gain pair follows the topology pin.
// - Control bit 7 forces the tone input on; 0 leaves auto detect.
// - Power-down pin low mutes outputs and enters low-current state.
// - Device acknowledges its own address in the ninth clock.
`timescale 1ns/1ns
module aicr_regs #(
    parameter int PWRUP_CYCLES = aicr_pkg::PWRUP_CYC
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic addr_select_hi_pin,
    input wire logic addr_select_lo_pin,
    input wire logic power_down_pin_b,
    input wire logic output_topology_select,
    output logic [5:0] right_gain_code,
    output logic [5:0] left_gain_code,
    output logic right_mute,
    output logic left_mute,
    output logic power_down,
    output logic input_source_select,
    output logic single_ended_output,
    output logic system_tone_forced,
    output logic powering_up
);
    aicr_line_if ev ();

    aicr_line_sync u_sync (
        .clk(clk),
        .rst_b(rst_b),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .ev(ev)
    );

    aicr_pkg::aicr_state_t state_q;
    logic [7:0] shift_q;
    logic [7:0] tx_q;
    logic [3:0] bit_q;
    logic [2:0] idx_q;
    logic rw_q;
    logic nak_q;
    logic oe_q;
    logic [7:0] stg_q [0:4];
    logic [7:0] rbg_q;
    logic [7:0] lbg_q;
    logic [7:0] rsg_q;
    logic [7:0] lsg_q;
    logic [6:0] mask_q;
    logic [7:0] ctrl_q;
    logic [1:0] asel_s1_q;
    logic [1:0] asel_q;
    logic [1:0] pin_s1_q;
    logic [1:0] pin_q;
    logic [15:0] pwr_cnt_q;
    logic busy_q;

    // Pin synchronisers: stage 1 is read only by stage 2
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            asel_s1_q <= 2'h0;
            asel_q <= 2'h0;
            pin_s1_q <= 2'h1;
            pin_q <= 2'h1;
        end else begin
            asel_s1_q <= {addr_select_hi_pin, addr_select_lo_pin};
            asel_q <= asel_s1_q;
            pin_s1_q <= {output_topology_select, power_down_pin_b};
            pin_q <= pin_s1_q;
        end
    end

    // Power-up sequence timer
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            pwr_cnt_q <= 16'h0000;
            busy_q <= 1'b1;
        end else if (busy_q) begin
            pwr_cnt_q <= pwr_cnt_q + 16'h0001;
            busy_q <= (pwr_cnt_q < 16'(PWRUP_CYCLES - 1));
        end
    end

    function automatic logic [7:0] rd_byte(input logic [2:0] i, input logic [7:0] rb, input logic [7:0] lb,
                                           input logic [7:0] rs, input logic [7:0] ls, input logic [7:0] mk,
                                           input logic [7:0] ct);
        unique case (i)
            aicr_pkg::IDX_R_BTL: rd_byte = rb;
            aicr_pkg::IDX_L_BTL: rd_byte = lb;
            aicr_pkg::IDX_R_SE: rd_byte = rs;
            aicr_pkg::IDX_L_SE: rd_byte = ls;
            aicr_pkg::IDX_MASK: rd_byte = mk;
            aicr_pkg::IDX_CTRL: rd_byte = ct;
            default: rd_byte = aicr_pkg::IDLE_BYTE;
        endcase
    endfunction

    wire [7:0] mask_rd = {busy_q, mask_q};
    wire [7:0] cur_byte = rd_byte(idx_q, rbg_q, lbg_q, rsg_q, lsg_q, mask_rd, ctrl_q);
    wire [7:0] first_byte = rd_byte(aicr_pkg::IDX_R_BTL, rbg_q, lbg_q, rsg_q, lsg_q, mask_rd, ctrl_q);
    wire [6:0] my_addr = {aicr_pkg::ADDR_FIXED, asel_q};
    wire addr_hit = (shift_q[7:1] == my_addr);
    wire byte_done = ev.scl_fall && (bit_q == 4'h8);
    wire commit = (state_q == aicr_pkg::ST_WR) && byte_done && (idx_q == aicr_pkg::IDX_CTRL);

    // Bus protocol engine
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_q <= aicr_pkg::ST_IDLE;
            shift_q <= 8'h00;
            tx_q <= 8'h00;
            bit_q <= 4'h0;
            idx_q <= 3'h0;
            rw_q <= 1'b0;
            nak_q <= 1'b1;
            oe_q <= 1'b0;
        end else if (ev.start) begin
            state_q <= aicr_pkg::ST_ADDR;
            bit_q <= 4'h0;
            oe_q <= 1'b0;
        end else if (ev.stop) begin
            state_q <= aicr_pkg::ST_IDLE;
            oe_q <= 1'b0;
        end else begin
            unique case (state_q)
                aicr_pkg::ST_IDLE: begin
                    oe_q <= 1'b0;
                end
                aicr_pkg::ST_ADDR: begin
                    if (ev.scl_rise) begin
                        shift_q <= {shift_q[6:0], ev.sda};
                        bit_q <= bit_q + 4'h1;
                    end else if (byte_done) begin
                        rw_q <= shift_q[0];
                        oe_q <= addr_hit;
                        state_q <= addr_hit ? aicr_pkg::ST_AACK : aicr_pkg::ST_IDLE;
                    end
                end
                aicr_pkg::ST_AACK: begin
                    if (ev.scl_fall) begin
                        bit_q <= 4'h0;
                        if (rw_q) begin
                            tx_q <= first_byte;
                            oe_q <= ~first_byte[7];
                            idx_q <= 3'h1;
                            state_q <= aicr_pkg::ST_RD;
                        end else begin
                            oe_q <= 1'b0;
                            idx_q <= 3'h0;
                            state_q <= aicr_pkg::ST_WR;
                        end
                    end
                end
                aicr_pkg::ST_WR: begin
                    if (ev.scl_rise) begin
                        shift_q <= {shift_q[6:0], ev.sda};
                        bit_q <= bit_q + 4'h1;
                    end else if (byte_done) begin
                        // Bytes past the sixth are refused
                        oe_q <= (idx_q < aicr_pkg::NUM_REGS);
                        idx_q <= idx_q + 3'h1;
                        state_q <= (idx_q < aicr_pkg::NUM_REGS) ? aicr_pkg::ST_WACK : aicr_pkg::ST_IDLE;
                    end
                end
                aicr_pkg::ST_WACK: begin
                    if (ev.scl_fall) begin
                        oe_q <= 1'b0;
                        bit_q <= 4'h0;
                        state_q <= aicr_pkg::ST_WR;
                    end
                end
                aicr_pkg::ST_RD: begin
                    if (ev.scl_fall) begin
                        if (bit_q == 4'h7) begin
                            oe_q <= 1'b0;
                            bit_q <= 4'h0;
                            state_q <= aicr_pkg::ST_RACK;
                        end else begin
                            tx_q <= {tx_q[6:0], 1'b0};
                            oe_q <= ~tx_q[6];
                            bit_q <= bit_q + 4'h1;
                        end
                    end
                end
                aicr_pkg::ST_RACK: begin
                    if (ev.scl_rise) begin
                        nak_q <= ev.sda;
                    end else if (ev.scl_fall) begin
                        if (!nak_q) begin
                            tx_q <= cur_byte;
                            oe_q <= ~cur_byte[7];
                            idx_q <= (idx_q < aicr_pkg::NUM_REGS) ? idx_q + 3'h1 : idx_q;
                            state_q <= aicr_pkg::ST_RD;
                        end else begin
                            state_q <= aicr_pkg::ST_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // Staging: all six registers change together on the sixth byte
    always_ff @(posedge clk) begin
        if ((state_q == aicr_pkg::ST_WR) && byte_done && (idx_q < aicr_pkg::IDX_CTRL)) begin
            stg_q[idx_q] <= shift_q;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rbg_q <= aicr_pkg::GAIN_RST;
            lbg_q <= aicr_pkg::GAIN_RST;
            rsg_q <= aicr_pkg::GAIN_RST;
            lsg_q <= aicr_pkg::GAIN_RST;
            mask_q <= aicr_pkg::MASK_RST[6:0];
            ctrl_q <= aicr_pkg::CTRL_RST;
        end else if (commit) begin
            rbg_q <= stg_q[aicr_pkg::IDX_R_BTL];
            lbg_q <= stg_q[aicr_pkg::IDX_L_BTL];
            rsg_q <= stg_q[aicr_pkg::IDX_R_SE];
            lsg_q <= stg_q[aicr_pkg::IDX_L_SE];
            mask_q <= stg_q[aicr_pkg::IDX_MASK][6:0];
            ctrl_q <= shift_q;
        end
    end

    // Pin or register control, per mask bit
    wire pd_eff = mask_q[aicr_pkg::MASK_PWRDN] ? ~pin_q[0] : ctrl_q[aicr_pkg::CTRL_PWRDN];
    wire se_eff = mask_q[aicr_pkg::MASK_TOPO] ? pin_q[1] : ctrl_q[aicr_pkg::CTRL_TOPO];
    wire hp_eff = mask_q[aicr_pkg::MASK_TOPO] ? pin_q[1] : ctrl_q[aicr_pkg::CTRL_INSRC];
    wire gsel_se = mask_q[aicr_pkg::MASK_TOPO] ? pin_q[1] : ctrl_q[aicr_pkg::CTRL_GSEL];
    wire tone_eff = ~mask_q[aicr_pkg::MASK_TONE] & ctrl_q[aicr_pkg::CTRL_TONE];
    wire [7:0] r_gain = gsel_se ? rsg_q : rbg_q;
    wire [7:0] l_gain = gsel_se ? lsg_q : lbg_q;
    wire mute_all = ctrl_q[aicr_pkg::CTRL_MUTE] | pd_eff;
    wire r_mute = r_gain[aicr_pkg::GAIN_MUTE_B] | r_gain[aicr_pkg::GAIN_MUTE_A] | mute_all;
    wire l_mute = l_gain[aicr_pkg::GAIN_MUTE_B] | l_gain[aicr_pkg::GAIN_MUTE_A] | mute_all;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            right_gain_code <= aicr_pkg::GAIN_RST[5:0];
            left_gain_code <= aicr_pkg::GAIN_RST[5:0];
            right_mute <= 1'b1;
            left_mute <= 1'b1;
            power_down <= 1'b1;
            input_source_select <= 1'b0;
            single_ended_output <= 1'b0;
            system_tone_forced <= 1'b0;
        end else begin
            right_gain_code <= r_gain[aicr_pkg::GAIN_CODE_W-1:0];
            left_gain_code <= l_gain[aicr_pkg::GAIN_CODE_W-1:0];
            right_mute <= r_mute;
            left_mute <= l_mute;
            power_down <= pd_eff;
            input_source_select <= hp_eff;
            single_ended_output <= se_eff;
            system_tone_forced <= tone_eff;
        end
    end

    assign sda_o = 1'b0;
    assign sda_oe = oe_q;
    assign powering_up = busy_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    pwr_busy_a: assert property ((pwr_cnt_q < 16'(PWRUP_CYCLES - 1)) |-> busy_q)
        else $error("power-up flag dropped early");
    pwr_done_a: assert property ($fell(busy_q) |-> ##1 !busy_q [*8])
        else $error("power-up flag came back");
    addr_ack_a: assert property ((state_q == aicr_pkg::ST_ADDR) && byte_done && addr_hit
        |=> oe_q && (state_q == aicr_pkg::ST_AACK))
        else $error("own address not acknowledged");
    addr_miss_a: assert property ((state_q == aicr_pkg::ST_ADDR) && byte_done && !addr_hit |=> !oe_q)
        else $error("foreign address acknowledged");
    commit_a: assert property (commit |=> (ctrl_q == $past(shift_q)) && (rbg_q == $past(stg_q[0])))
        else $error("six-byte write not committed");
    hold_a: assert property (!commit && !$past(commit) |=> $stable(ctrl_q) && $stable(mask_q))
        else $error("register changed outside full write");
    tone_mask_a: assert property (mask_q[aicr_pkg::MASK_TONE] |=> !system_tone_forced)
        else $error("tone forced while masked");
    topo_pin_a: assert property (mask_q[aicr_pkg::MASK_TOPO] && $stable(pin_q[1]) && $stable(mask_q)
        |=> single_ended_output == $past(pin_q[1]) && input_source_select == $past(pin_q[1]))
        else $error("topology not following pin");
    mute_a: assert property (ctrl_q[aicr_pkg::CTRL_MUTE] && $stable(ctrl_q) |=> right_mute && left_mute)
        else $error("mute bit ignored");
    pd_pin_a: assert property (mask_q[aicr_pkg::MASK_PWRDN] && !pin_q[0] && $stable(mask_q)
        |=> power_down && right_mute)
        else $error("power-down pin ignored");
    rd_ctrl_a: assert property ((state_q == aicr_pkg::ST_RACK) && ev.scl_fall && !nak_q
        && (idx_q == aicr_pkg::IDX_CTRL) |=> (tx_q == ctrl_q) && (state_q == aicr_pkg::ST_RD))
        else $error("sixth read byte is not the control register");

    wr_seen_c: cover property (commit);
    rd_six_c: cover property ((state_q == aicr_pkg::ST_RACK) && (idx_q == aicr_pkg::NUM_REGS) && ev.scl_fall);
    pwr_done_c: cover property ($fell(busy_q));
endmodule

// *** tb/aicr_i2c_master.sv ***
/*
 * Behavioural two-wire bus master that reaches the amplifier register set.
 * Assumes the bench resolves sda from its pull-low and the device's enable.
 */
`timescale 1ns/1ns
module aicr_i2c_master (
    input wire logic clk,
    output logic scl,
    output logic sda_pull_low,
    input wire logic sda_line
);
    // Half bus clock period in system clocks: 80 ns bus clock
    int half_clks = 10;

    initial begin
        scl = 1'b1;
        sda_pull_low = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // Data only moves while the bus clock is low
    task automatic bit_out(input logic b);
        tick(half_clks / 2);
        sda_pull_low = !b;
        tick(half_clks - half_clks / 2);
        scl = 1'b1;
        tick(half_clks);
        scl = 1'b0;
    endtask

    task automatic bit_in(output logic b);
        tick(half_clks / 2);
        sda_pull_low = 1'b0;
        tick(half_clks - half_clks / 2);
        scl = 1'b1;
        tick(half_clks / 2);
        b = sda_line;
        tick(half_clks - half_clks / 2);
        scl = 1'b0;
    endtask

    // Works from idle and as a repeated start
    task automatic start();
        // Data must fall while the bus clock is high, so the clock is not dropped first
        tick(half_clks / 2);
        sda_pull_low = 1'b0;
        tick(half_clks - half_clks / 2);
        scl = 1'b1;
        tick(half_clks);
        sda_pull_low = 1'b1;
        tick(half_clks);
        scl = 1'b0;
    endtask

    task automatic stop();
        tick(half_clks / 2);
        sda_pull_low = 1'b1;
        tick(half_clks - half_clks / 2);
        scl = 1'b1;
        tick(half_clks);
        sda_pull_low = 1'b0;
        tick(half_clks);
    endtask

    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_out(b[i]);
        end
        bit_in(r);
        ack = (r === 1'b0);
    endtask

    task automatic recv_byte(output logic [7:0] b, input logic give_ack);
        logic v;
        for (int i = 7; i >= 0; i--) begin
            bit_in(v);
            b[i] = v;
        end
        bit_out(!give_ack);
    endtask

    // acks bit 0 is the address, bit i the i-th data byte
    task automatic write_block(input logic [6:0] addr, input logic [47:0] data, input int n,
                               output logic [7:0] acks);
        logic a;
        acks = 8'h00;
        start();
        send_byte({addr, 1'b0}, a);
        acks[0] = a;
        for (int i = 0; i < n; i++) begin
            send_byte(data[47 - 8 * i -: 8], a);
            acks[i + 1] = a;
        end
        stop();
    endtask

    // Last byte is not acknowledged so the device lets go of the line
    task automatic read_block(input logic [6:0] addr, input int n, output logic [47:0] data,
                              output logic ack);
        logic [7:0] b;
        data = 48'h0;
        start();
        send_byte({addr, 1'b1}, ack);
        for (int i = 0; i < n && ack; i++) begin
            recv_byte(b, i < n - 1);
            data[47 - 8 * i -: 8] = b;
        end
        stop();
    endtask
endmodule

// *** tb/tb.sv ***
/*
 * Self-checking bench for the amplifier control register set.
 * Assumes sda has a pull-up and the master model owns the bus clock.
 */
`timescale 1ns/1ns
module tb;
    localparam int PWRUP = 20;
    logic clk, rst_b, scl, sda_pull_low, sda_line, sda_o, sda_oe;
    logic hi_pin, lo_pin, pd_pin_b, topo_pin, ack;
    logic [5:0] right_gain_code, left_gain_code;
    logic right_mute, left_mute, power_down, input_source_select;
    logic single_ended_output, system_tone_forced, powering_up;
    logic [7:0] exp_regs [0:5];
    logic [6:0] flips [0:3] = '{7'h02, 7'h04, 7'h40, 7'h10};
    logic [7:0] acks;
    logic [47:0] rd;
    int miscompares = 0;
    int n_checks = 0;
    int cycles = 0;

    assign sda_line = (sda_pull_low || (sda_oe && !sda_o)) ? 1'b0 : 1'b1;

    aicr_regs #(.PWRUP_CYCLES(PWRUP)) aicr_regs_inst (
        .clk(clk), .rst_b(rst_b), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe),
        .addr_select_hi_pin(hi_pin), .addr_select_lo_pin(lo_pin), .power_down_pin_b(pd_pin_b),
        .output_topology_select(topo_pin), .right_gain_code(right_gain_code),
        .left_gain_code(left_gain_code), .right_mute(right_mute), .left_mute(left_mute),
        .power_down(power_down), .input_source_select(input_source_select),
        .single_ended_output(single_ended_output), .system_tone_forced(system_tone_forced),
        .powering_up(powering_up)
    );

    aicr_i2c_master aicr_i2c_master_inst (
        .clk(clk), .scl(scl), .sda_pull_low(sda_pull_low), .sda_line(sda_line)
    );

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        n_checks++;
        if (seen !== want) begin
            miscompares++;
            $display("Error at %0t ns: saw %h, expected %h", $time, seen, want);
        end
    endtask

    task automatic final_report();
        $display("Checks %0d, mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    function automatic logic [6:0] dev_addr();
        return {aicr_pkg::ADDR_FIXED, hi_pin, lo_pin};
    endfunction

    // Expected decode worked out from the stored bytes and the pins
    task automatic check_outs();
        logic [7:0] m, c, rg, lg, want, seen;
        logic pd, gs;
        m = exp_regs[4];
        c = exp_regs[5];
        pd = m[0] ? !pd_pin_b : c[0];
        gs = m[1] ? topo_pin : c[6];
        rg = gs ? exp_regs[2] : exp_regs[0];
        lg = gs ? exp_regs[3] : exp_regs[1];
        want = {2'h0, rg[7] | rg[6] | c[3] | pd, lg[7] | lg[6] | c[3] | pd, pd,
                m[1] ? topo_pin : c[1], m[1] ? topo_pin : c[5], !m[2] & c[7]};
        seen = {2'h0, right_mute, left_mute, power_down, input_source_select, single_ended_output,
                system_tone_forced};
        check({2'h0, right_gain_code}, {2'h0, rg[5:0]});
        check({2'h0, left_gain_code}, {2'h0, lg[5:0]});
        check(seen, want);
    endtask

    // Gains are only written after the power-up indicator has cleared
    task automatic reset_and_check();
        rst_b = 1'b0;
        tick(2);
        rst_b = 1'b1;
        exp_regs = '{8'h3F, 8'h3F, 8'h3F, 8'h3F, 8'hFF, 8'h00};
        tick(6);
        check({7'h0, powering_up}, 8'h01);
        check_outs();
        tick(PWRUP);
        check({7'h0, powering_up}, 8'h00);
        exp_regs[4] = 8'h7F;
    endtask

    task automatic read_check();
        aicr_i2c_master_inst.read_block(dev_addr(), 6, rd, ack);
        check({7'h0, ack}, 8'h01);
        for (int i = 0; i < 6; i++) begin
            check(rd[47 - 8 * i -: 8], exp_regs[i]);
        end
    endtask

    task automatic write_regs(input logic [47:0] v);
        aicr_i2c_master_inst.write_block(dev_addr(), v, 6, acks);
        check(acks, 8'h7F);
        for (int i = 0; i < 6; i++) begin
            exp_regs[i] = v[47 - 8 * i -: 8];
        end
        exp_regs[4][7] = 1'b0;
        tick(6);
        check_outs();
    endtask

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    always @(posedge clk) begin
        cycles++;
        if (cycles == 40000) begin
            miscompares++;
            final_report();
        end
    end

    initial begin
        rst_b = 1'b0;
        hi_pin = 1'b0;
        lo_pin = 1'b0;
        pd_pin_b = 1'b1;
        topo_pin = 1'b0;
        reset_and_check();
        read_check();
        for (int k = 0; k < 4; k++) begin
            {hi_pin, lo_pin} = k[1:0];
            tick(6);
            aicr_i2c_master_inst.read_block(dev_addr(), 1, rd, ack);
            check({7'h0, ack}, 8'h01);
            check(rd[47:40], 8'h3F);
            aicr_i2c_master_inst.read_block(dev_addr() ^ flips[k], 1, rd, ack);
            check({7'h0, ack}, 8'h00);
        end
        write_regs({8'h05, 8'h0A, 8'h15, 8'h2A, 8'h00, 8'h10});
        write_regs({8'h05, 8'h0A, 8'h15, 8'h2A, 8'h00, 8'hF3});
        write_regs({8'h05, 8'h0A, 8'h15, 8'h2A, 8'h00, 8'h58});
        write_regs({8'h45, 8'h8A, 8'h15, 8'h2A, 8'h78, 8'h10});
        read_check();
        write_regs({8'h45, 8'h8A, 8'hD5, 8'h2A, 8'h87, 8'hF3});
        for (int k = 0; k < 4; k++) begin
            {pd_pin_b, topo_pin} = k[1:0];
            tick(6);
            check_outs();
        end
        read_check();
        aicr_i2c_master_inst.write_block(dev_addr(), {8'h01, 8'h02, 8'h03, 24'h0}, 3, acks);
        check(acks, 8'h0F);
        read_check();
        check_outs();
        reset_and_check();
        read_check();
        final_report();
    end
endmodule
